// [src/fpc_cmd_logic.v]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"

module fpc_cmd_logic #(
  parameter [19:0] PWRUP_CYC = `FPC_PWRUP_CYC
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        sck,
  input  wire        cs_n,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe_n,
  input  wire        quad_wide_mode,
  input  wire        prog_fail,
  input  wire        guard_wr,
  input  wire        guard_val,
  output wire        busy_flag,
  output reg         write_latch,
  output reg         program_error,
  output reg  [7:0]  lock_status,
  output reg  [15:0] region_protection_config,
  output reg         status_guard_bit,
  output reg         reset_armed,
  output reg         powerup_done
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_PROG  = 3'h1;
  localparam [2:0] ST_HANG  = 3'h2;
  localparam [2:0] ST_SRST  = 3'h3;
  localparam [2:0] ST_PWRUP = 3'h4;

  localparam [1:0] K_CFG  = 2'h0;
  localparam [1:0] K_LOCK = 2'h1;
  localparam [1:0] K_SECP = 2'h2;
  localparam [1:0] K_SECU = 2'h3;

  localparam [19:0] PROG_LAST = `FPC_PROG_CYC - 20'h00001;
  localparam [19:0] SRST_LAST = `FPC_SRST_CYC - 20'h00001;
  localparam [19:0] PWRUP_LAST = PWRUP_CYC - 20'h00001;

  // Clocks needed to carry a number of data bits in the current width.
  function [6:0] need_clks;
    input [6:0] bits;
    input       quad;
    begin
      need_clks = quad ? {2'b00, bits[6:2]} : bits;
    end
  endfunction

  // Puts one output unit of a byte on the lines: a nibble, or one bit on IO1.
  function [3:0] pick_unit;
    input [7:0] data;
    input [2:0] idx;
    input       quad;
    begin
      if (quad) begin
        pick_unit = idx[0] ? data[3:0] : data[7:4];
      end else begin
        pick_unit = {2'b00, data[3'h7 - idx], 1'b0};
      end
    end
  endfunction

  // Reorders a received stream so the first byte lands in the low byte.
  function [63:0] swap_bytes;
    input [63:0] stream;
    integer k;
    begin
      swap_bytes = 64'h0000000000000000;
      for (k = 0; k < 8; k = k + 1) begin
        swap_bytes[8*k +: 8] = stream[56-8*k +: 8];
      end
    end
  endfunction

  reg        sck_s1_q, sck_s2_q, sck_s3_q;
  reg        cs_s1_q, cs_s2_q, cs_s3_q;
  reg [3:0]  io_s1_q, io_s2_q;
  reg        quad_q;
  reg [7:0]  op_q;
  reg [3:0]  opcnt_q;
  reg        op_ok_q;
  reg [6:0]  ccnt_q;
  reg        ovf_q;
  reg [63:0] sr_q;
  reg [2:0]  state_q;
  reg [1:0]  kind_q;
  reg [19:0] tmr_q;
  reg [63:0] stage_q;
  reg        mism_q;

  wire       sck_rise    = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
  wire       sck_fall    = ~sck_s2_q & sck_s3_q & ~cs_s2_q;
  wire       frame_start = ~cs_s2_q & cs_s3_q;
  wire       frame_end   = cs_s2_q & ~cs_s3_q;
  wire [3:0] unit_bits   = quad_q ? 4'h4 : 4'h1;
  wire [6:0] rdk         = ccnt_q - 7'h01;
  wire       len16_ok    = ~ovf_q & (ccnt_q == need_clks(`FPC_CFG_BITS, quad_q));
  wire       len64_ok    = ~ovf_q & (ccnt_q == need_clks(`FPC_SECRET_BITS, quad_q));
  wire       no_data     = ~ovf_q & (ccnt_q == 7'h00);
  wire       pw_mode     = ~region_protection_config[`FPC_CFG_PWMODE];
  wire [7:0] stage_byte  = stage_q[{tmr_q[2:0], 3'b000} +: 8];
  wire [7:0] cmp_byte    = stage_q[{tmr_q[2:0] - 3'h1, 3'b000} +: 8];
  wire       mem_wr      = (state_q == ST_PROG) & (kind_q == K_SECP) & (tmr_q < 20'h00008);
  wire [2:0] mem_raddr;
  wire [7:0] mem_rdata;

  assign busy_flag = (state_q != ST_IDLE);
  assign mem_raddr = (state_q == ST_PROG) ? tmr_q[2:0] : (quad_q ? rdk[3:1] : rdk[5:3]);

  fpc_secret_mem u_secret (
    .clk       (clk),
    .reset     (reset),
    .wr_en     (mem_wr),
    .wr_addr   (tmr_q[2:0]),
    .wr_data   (stage_byte),
    .rd_addr   (mem_raddr),
    .rd_data_q (mem_rdata)
  );

  // Two-stage synchronisers for the pins, plus a third stage for edge finding.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      io_s1_q  <= 4'h0;
      io_s2_q  <= 4'h0;
    end else begin
      sck_s1_q <= sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      io_s1_q  <= io_in;
      io_s2_q  <= io_s1_q;
    end
  end

  // Frame capture: opcode shifting, then data clocks counted after the opcode.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      quad_q  <= 1'b0;
      op_q    <= 8'h00;
      opcnt_q <= 4'h0;
      op_ok_q <= 1'b0;
      ccnt_q  <= 7'h00;
      ovf_q   <= 1'b0;
      sr_q    <= 64'h0000000000000000;
    end else if (frame_start) begin
      quad_q  <= quad_wide_mode;
      opcnt_q <= 4'h0;
      op_ok_q <= 1'b0;
      ccnt_q  <= 7'h00;
      ovf_q   <= 1'b0;
    end else if (sck_rise) begin
      if (!op_ok_q) begin
        op_q    <= quad_q ? {op_q[3:0], io_s2_q} : {op_q[6:0], io_s2_q[0]};
        opcnt_q <= opcnt_q + unit_bits;
        if ((opcnt_q + unit_bits) == 4'h8) begin
          op_ok_q <= 1'b1;
        end
      end else begin
        ccnt_q <= ccnt_q + 7'h01;
        if (ccnt_q == 7'h7F) begin
          ovf_q <= 1'b1;
        end
        sr_q <= quad_q ? {sr_q[59:0], io_s2_q} : {sr_q[62:0], io_s2_q[0]};
      end
    end
  end

  // Read data leave on falling clock edges after the dummy clock.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      io_out  <= 4'h0;
      io_oe_n <= 4'hF;
    end else if (cs_s2_q) begin
      io_oe_n <= 4'hF;
    end else if (sck_fall && op_ok_q && ccnt_q != 7'h00) begin
      if (op_q == `FPC_OP_LKRD) begin
        io_out  <= pick_unit(lock_status, rdk[2:0], quad_q);
        io_oe_n <= quad_q ? 4'h0 : 4'hD;
      end else if (op_q == `FPC_OP_SCRD) begin
        io_out  <= pick_unit(pw_mode ? 8'h00 : mem_rdata, rdk[2:0], quad_q);
        io_oe_n <= quad_q ? 4'h0 : 4'hD;
      end
    end
  end

  // Self-timed operations, status flags and command execution at frame end.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q                  <= ST_PWRUP;
      kind_q                   <= K_CFG;
      tmr_q                    <= 20'h00000;
      stage_q                  <= 64'h0000000000000000;
      mism_q                   <= 1'b0;
      write_latch              <= 1'b0;
      program_error            <= 1'b0;
      lock_status              <= `FPC_LOCK_RST;
      region_protection_config <= `FPC_CFG_RST;
      status_guard_bit         <= 1'b0;
      reset_armed              <= 1'b0;
      powerup_done             <= 1'b0;
    end else begin
      // The guard bit follows its writer and is untouched by software reset.
      if (guard_wr) begin
        status_guard_bit <= guard_val;
      end
      case (state_q)
        ST_PROG: begin
          tmr_q <= tmr_q + 20'h00001;
          if (kind_q == K_SECU && tmr_q >= 20'h00001 && tmr_q <= 20'h00008) begin
            if (mem_rdata != cmp_byte) begin
              mism_q <= 1'b1;
            end
          end
          if (tmr_q == PROG_LAST) begin
            state_q <= ST_IDLE;
            case (kind_q)
              K_CFG: begin
                region_protection_config <= stage_q[15:0];
                write_latch              <= 1'b0;
                program_error            <= prog_fail;
              end
              K_LOCK: begin
                lock_status[`FPC_LOCK_SEC]   <= 1'b0;
                lock_status[`FPC_LOCK_GUARD] <= region_protection_config[`FPC_CFG_GUARD];
                write_latch                  <= 1'b0;
                program_error                <= prog_fail;
              end
              K_SECP: begin
                write_latch   <= 1'b0;
                program_error <= prog_fail;
              end
              default: begin
                if (mism_q) begin
                  program_error <= 1'b1;
                  state_q       <= ST_HANG;
                end else begin
                  lock_status[`FPC_LOCK_SEC] <= 1'b1;
                end
              end
            endcase
          end
        end
        ST_SRST: begin
          tmr_q <= tmr_q + 20'h00001;
          if (tmr_q == SRST_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PWRUP: begin
          tmr_q <= tmr_q + 20'h00001;
          if (tmr_q == PWRUP_LAST) begin
            state_q      <= ST_IDLE;
            powerup_done <= 1'b1;
          end
        end
        ST_HANG: begin
          tmr_q <= 20'h00000;
        end
        default: begin
          tmr_q <= 20'h00000;
        end
      endcase

      // Decoding at chip select rise; it comes last so it wins over completion.
      if (frame_end && op_ok_q) begin
        reset_armed <= (op_q == `FPC_OP_RARM) && no_data;
        case (op_q)
          `FPC_OP_WRITE_EN: begin
            if (!busy_flag && no_data) begin
              write_latch <= 1'b1;
            end
          end
          `FPC_OP_CLR_STATUS: begin
            if (no_data && (state_q == ST_IDLE || state_q == ST_HANG)) begin
              program_error <= 1'b0;
              state_q       <= ST_IDLE;
            end
          end
          `FPC_OP_RST: begin
            if (reset_armed && no_data) begin
              write_latch   <= 1'b0;
              program_error <= 1'b0;
              lock_status   <= (`FPC_LOCK_RST & 8'hFE) | (lock_status & 8'h01);
              tmr_q         <= 20'h00000;
              state_q       <= powerup_done ? ST_SRST : ST_PWRUP;
            end
          end
          `FPC_OP_CFGP: begin
            if (!busy_flag && write_latch && len16_ok) begin
              stage_q <= {48'h000000000000, sr_q[7:0], sr_q[15:8]};
              kind_q  <= K_CFG;
              tmr_q   <= 20'h00000;
              state_q <= ST_PROG;
            end
          end
          `FPC_OP_LKLK: begin
            if (!busy_flag && write_latch && no_data) begin
              kind_q  <= K_LOCK;
              tmr_q   <= 20'h00000;
              state_q <= ST_PROG;
            end
          end
          `FPC_OP_SCPG: begin
            if (!busy_flag && write_latch && len64_ok && !pw_mode) begin
              stage_q <= swap_bytes(sr_q);
              kind_q  <= K_SECP;
              tmr_q   <= 20'h00000;
              state_q <= ST_PROG;
            end
          end
          `FPC_OP_SCUL: begin
            if (!busy_flag && len64_ok) begin
              stage_q <= swap_bytes(sr_q);
              mism_q  <= 1'b0;
              kind_q  <= K_SECU;
              tmr_q   <= 20'h00000;
              state_q <= ST_PROG;
            end
          end
          default: begin
            kind_q <= kind_q; // Reads and unknown opcodes leave a running timer alone.
          end
        endcase
      end
    end
  end

endmodule // fpc_cmd_logic

`default_nettype wire

// [include/fpc_regs.vh]
`ifndef FPC_REGS_VH
`define FPC_REGS_VH

// Opcodes decoded by the command logic.
`define FPC_OP_WRITE_EN   8'h06
`define FPC_OP_CLR_STATUS 8'h30
`define FPC_OP_CFGP   8'h2F
`define FPC_OP_LKRD   8'hA7
`define FPC_OP_LKLK   8'hA6
`define FPC_OP_SCRD   8'hE7
`define FPC_OP_SCPG   8'hE8
`define FPC_OP_SCUL   8'hEA
`define FPC_OP_RARM   8'h66
`define FPC_OP_RST    8'h99

// Field positions.
`define FPC_LOCK_SEC   0
`define FPC_LOCK_GUARD 6
`define FPC_CFG_PWMODE 2
`define FPC_CFG_GUARD  6

// Reset values of the stored registers.
`define FPC_CFG_RST    16'hFFFF
`define FPC_LOCK_RST   8'h41
`define FPC_SECRET_RST 8'hFF

// Data lengths of the write frames in bits.
`define FPC_CFG_BITS    7'h10
`define FPC_SECRET_BITS 7'h40

// Timing: figures in ns and derived clock counts at 100 MHz, all 20 bits wide
// so that the counts meet the 20-bit timer without being cut.
`define FPC_CLK_NS    20'h0000A
`define FPC_PROG_NS   20'h007D0
`define FPC_SRST_NS   20'h02710
`define FPC_PWRUP_NS  20'h493E0
`define FPC_PROG_CYC  ((`FPC_PROG_NS + `FPC_CLK_NS - 20'h00001) / `FPC_CLK_NS)
`define FPC_SRST_CYC  ((`FPC_SRST_NS + `FPC_CLK_NS - 20'h00001) / `FPC_CLK_NS)
`define FPC_PWRUP_CYC ((`FPC_PWRUP_NS + `FPC_CLK_NS - 20'h00001) / `FPC_CLK_NS)

`endif

// [src/fpc_secret_mem.v]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"

module fpc_secret_mem (
  input  wire       clk,
  input  wire       reset,
  input  wire       wr_en,
  input  wire [2:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [2:0] rd_addr,
  output reg  [7:0] rd_data_q
);

  reg     [7:0] mem_q [0:7];
  integer       i;

  // Eight byte cells holding the secret; read data leave through a register.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_q[i] <= `FPC_SECRET_RST;
      end
      rd_data_q <= 8'h00;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule // fpc_secret_mem

`default_nettype wire

// [dv/fpc_cmd_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module fpc_cmd_checker #(
  parameter [19:0] PWRUP_CYC = 20'd50
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic [3:0]  io_oe_n,
  input wire logic        guard_wr,
  input wire logic        busy_flag,
  input wire logic        write_latch,
  input wire logic        program_error,
  input wire logic [7:0]  lock_status,
  input wire logic [15:0] region_protection_config,
  input wire logic        status_guard_bit,
  input wire logic        reset_armed,
  input wire logic        powerup_done
);
  // All checks run on the system clock and rest during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_idle_oe_off: assert property ((cs_n)[*6] |-> io_oe_n == 4'hF)
    else $error("pins driven outside a frame");
  a_oe_legal_set: assert property (io_oe_n inside {4'hF, 4'hD, 4'h0})
    else $error("illegal output enable pattern");
  a_latch_busy_hold: assert property (busy_flag && $past(busy_flag) |-> !$rose(write_latch))
    else $error("write latch set while busy");
  a_latch_on_decode: assert property ($rose(write_latch) |-> cs_n && $past(cs_n))
    else $error("write latch set inside a frame");
  a_cfg_idle_stable: assert property (
    !busy_flag && !$past(busy_flag) && !$past(busy_flag, 2)
    |-> $stable(region_protection_config))
    else $error("config changed while idle");
  a_lock_idle_stable: assert property (
    !busy_flag && !$past(busy_flag) && !$past(busy_flag, 2)
    |-> $stable(lock_status))
    else $error("lock status changed while idle");
  a_busy_after_frame: assert property ($rose(busy_flag) |-> cs_n && $past(cs_n, 2))
    else $error("busy rose without a closed frame");
  a_error_hang_busy: assert property ($rose(program_error) && busy_flag && cs_n |=> busy_flag)
    else $error("busy dropped with error raised");
  a_arm_frame_hold: assert property ((!cs_n)[*3] |-> $stable(reset_armed))
    else $error("arm changed inside a frame");
  a_powerup_busy: assert property (!powerup_done |-> busy_flag)
    else $error("idle before power-up completed");
  a_guard_kept: assert property (!$past(guard_wr) |-> $stable(status_guard_bit))
    else $error("guard bit changed without a load");

  // Main scenarios reached.
  c_busy: cover property ($rose(busy_flag));
  c_error: cover property ($rose(program_error));
  c_arm_drop: cover property ($fell(reset_armed));
  c_latch: cover property ($rose(write_latch));
endmodule // fpc_cmd_checker

bind fpc_cmd_logic fpc_cmd_checker #(.PWRUP_CYC(PWRUP_CYC)) i_fpc_cmd_checker (
  .clk(clk), .reset(reset), .cs_n(cs_n), .io_oe_n(io_oe_n), .guard_wr(guard_wr),
  .busy_flag(busy_flag), .write_latch(write_latch), .program_error(program_error),
  .lock_status(lock_status), .region_protection_config(region_protection_config),
  .status_guard_bit(status_guard_bit), .reset_armed(reset_armed), .powerup_done(powerup_done));
`default_nettype wire

// [dv/fpc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fpc_host_model (
  output var logic       sck,
  output var logic       cs_n,
  output var logic [3:0] host_io,
  input wire logic [3:0] io_wire
);
  // The serial clock stands low and select high between frames.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_io = 4'hA;
  end

  // One frame: opcode, data bits, then read clocks with one dummy clock first.
  task automatic frame(input logic [7:0] op, input int dbits, input logic [63:0] dat,
                       input logic quad, input int rclks, output logic [63:0] rd);
    logic [71:0] s;
    int          w;
    int          n;
    begin
      w = quad ? 4 : 1;
      n = (8 + dbits) / w;
      s = {op, dat << (64 - dbits)};
      rd = 64'h0;
      cs_n = 1'b0;
      for (int i = 0; i < n + rclks; i++) begin
        // Released lines toggle so a stale level never reads as data.
        host_io = (i < n) ? (quad ? s[71:68] : {~host_io[3:1], s[71]}) : ~host_io;
        s = s << w;
        #62.5 sck = 1'b1;
        if (i > n) rd = quad ? {rd[59:0], io_wire} : {rd[62:0], io_wire[1]};
        #62.5 sck = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      host_io = ~host_io;
      #250;
    end
  endtask
endmodule // fpc_host_model
`default_nettype wire

// [dv/fpc_cmd_logic_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"
module fpc_cmd_logic_tb;
  localparam logic [63:0] SEC = 64'h0123456789ABCDEF;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        quad_wide_mode = 1'b0;
  logic        prog_fail = 1'b0;
  logic        guard_wr = 1'b0;
  logic        guard_val = 1'b0;
  logic [63:0] rd;
  int          fail_count = 0;
  int          compares = 0;
  wire         sck;
  wire         cs_n;
  wire  [3:0]  host_io;
  wire  [3:0]  io_in;
  wire  [3:0]  io_out;
  wire  [3:0]  io_oe_n;
  wire         busy_flag;
  wire         write_latch;
  wire         program_error;
  wire  [7:0]  lock_status;
  wire  [15:0] region_protection_config;
  wire         status_guard_bit;
  wire         reset_armed;
  wire         powerup_done;

  // Each line carries the device level where it drives, else the host level.
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & host_io);

  fpc_cmd_logic #(.PWRUP_CYC(20'd50)) i_fpc_cmd_logic (
    .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .quad_wide_mode(quad_wide_mode), .prog_fail(prog_fail),
    .guard_wr(guard_wr), .guard_val(guard_val), .busy_flag(busy_flag),
    .write_latch(write_latch), .program_error(program_error), .lock_status(lock_status),
    .region_protection_config(region_protection_config), .status_guard_bit(status_guard_bit),
    .reset_armed(reset_armed), .powerup_done(powerup_done));

  fpc_host_model i_fpc_host_model (.sck(sck), .cs_n(cs_n), .host_io(host_io), .io_wire(io_in));

  // System clock at 100 MHz.
  always #5 clk = ~clk;

  function automatic logic [63:0] bswap(input logic [63:0] d);
    for (int i = 0; i < 8; i++) bswap[8*i +: 8] = d[56-8*i +: 8];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] op, input int dbits, input logic [63:0] dat,
                      input int rclks);
    i_fpc_host_model.frame(op, dbits, dat, quad_wide_mode, rclks, rd);
  endtask

  // Waits for the busy flag to drop, bounded.
  task automatic idle();
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check(n < 5000, 1'b1);
  endtask

  task automatic complete_run();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #900000;
    fail_count++;
    complete_run();
  end

  // Main sequence of command frames.
  initial begin
    repeat (20) @(posedge clk);
    check(busy_flag, 1'b1);
    check(lock_status, 8'h41);
    reset <= 1'b0;
    idle();
    check(powerup_done, 1'b1);
    send(`FPC_OP_CFGP, 16, 64'h0000, 0);
    idle();
    check(region_protection_config, 16'hFFFF);
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    check(write_latch, 1'b1);
    send(`FPC_OP_CFGP, 15, 64'h0000, 0);
    idle();
    check({write_latch, region_protection_config}, 17'h1FFFF);
    send(`FPC_OP_SCPG, 64, bswap(SEC), 0);
    check(busy_flag, 1'b1);
    idle();
    check({write_latch, program_error}, 2'b00);
    send(`FPC_OP_SCRD, 0, 0, 65);
    check(rd, bswap(SEC));
    quad_wide_mode <= 1'b1;
    @(posedge clk);
    send(`FPC_OP_SCRD, 0, 0, 17);
    check(rd, bswap(SEC));
    quad_wide_mode <= 1'b0;
    @(posedge clk);
    send(`FPC_OP_LKRD, 0, 0, 17);
    check(rd[15:0], 16'h4141);
    prog_fail <= 1'b1;
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    send(`FPC_OP_CFGP, 16, 64'hFFFF, 0);
    idle();
    check({write_latch, program_error}, 2'b01);
    prog_fail <= 1'b0;
    send(`FPC_OP_CLR_STATUS, 0, 0, 0);
    idle();
    check(program_error, 1'b0);
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    send(`FPC_OP_LKLK, 0, 0, 0);
    check(busy_flag, 1'b1);
    idle();
    check({write_latch, lock_status}, 9'h040);
    send(`FPC_OP_SCUL, 64, bswap(~SEC), 0);
    repeat (500) @(posedge clk);
    check({busy_flag, program_error}, 2'b11);
    send(`FPC_OP_CLR_STATUS, 0, 0, 0);
    idle();
    check(program_error, 1'b0);
    send(`FPC_OP_SCUL, 64, bswap(SEC), 0);
    idle();
    check(lock_status, 8'h41);
    quad_wide_mode <= 1'b1;
    @(posedge clk);
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    send(`FPC_OP_CFGP, 16, 64'hBBFF, 0);
    idle();
    check(region_protection_config, 16'hFFBB);
    quad_wide_mode <= 1'b0;
    @(posedge clk);
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    send(`FPC_OP_SCPG, 64, 0, 0);
    check({busy_flag, write_latch}, 2'b01);
    idle();
    send(`FPC_OP_SCRD, 0, 0, 65);
    check(rd, 64'h0);
    @(posedge clk);
    guard_val <= 1'b1;
    guard_wr <= 1'b1;
    @(posedge clk);
    guard_wr <= 1'b0;
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    send(`FPC_OP_LKLK, 0, 0, 0);
    idle();
    check(lock_status, 8'h00);
    send(`FPC_OP_RARM, 0, 0, 0);
    check(reset_armed, 1'b1);
    send(`FPC_OP_WRITE_EN, 0, 0, 0);
    check(reset_armed, 1'b0);
    send(`FPC_OP_RST, 0, 0, 0);
    check(busy_flag, 1'b0);
    send(`FPC_OP_RARM, 0, 0, 0);
    send(`FPC_OP_RST, 0, 0, 0);
    check(busy_flag, 1'b1);
    idle();
    check({write_latch, lock_status}, 9'h040);
    check({status_guard_bit, region_protection_config}, 17'h1FFBB);
    complete_run();
  end
endmodule // fpc_cmd_logic_tb
`default_nettype wire
